/* design/cfsf_framer.sv */
// parser of the field, block and sequence structure of the coded stream
`timescale 1ns/1ps
module cfsf_framer
    import cfsf_pkg::*;
#(
    parameter logic [5:0] BLOCKS = CFSF_BLOCKS_DEF
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire cfsf_tok_s tok_in,
    output cfsf_ev_s ev_out,
    output logic seq_open
);
    // zero blocks would leave a field with only its first block; the top code is kept spare
    if (BLOCKS == 6'h00 || BLOCKS == 6'h3f)
    begin
        $error("cfsf_framer: BLOCKS out of range");
    end

    cfsf_state_e state_r, state_nxt;
    logic exp_two_r, exp_two_nxt;
    logic open_r, open_nxt;
    logic [CFSF_CNT_W-1:0] cnt_r, cnt_nxt;
    cfsf_ev_s ev_r, ev_nxt;

    logic is_sob;
    logic is_sof;
    logic is_eos;
    logic is_data;
    logic field_full;

    assign is_sob = tok_in.kind inside {CFSF_TK_BLOCK_START_KIND_ONE, CFSF_TK_BLOCK_START_KIND_TWO,
        CFSF_TK_BLOCK_START_KIND_THREE, CFSF_TK_BLOCK_START_KIND_FOUR, CFSF_TK_BLOCK_START_KIND_FIVE};
    assign is_sof = tok_in.kind inside {CFSF_TK_FIELD_ONE_START_CODE, CFSF_TK_FIELD_TWO_START_CODE};
    assign is_eos = tok_in.kind == CFSF_TK_EOS;
    assign is_data = tok_in.kind == CFSF_TK_DATA;
    assign field_full = cnt_r == BLOCKS;

    always_comb
    begin
        state_nxt = state_r;
        exp_two_nxt = exp_two_r;
        open_nxt = open_r;
        cnt_nxt = cnt_r;
        // pulses clear every cycle; level fields keep their last value
        ev_nxt = '0;
        ev_nxt.field_two = ev_r.field_two;
        ev_nxt.block_kind = ev_r.block_kind;
        ev_nxt.block_index = ev_r.block_index;
        ev_nxt.bin_width_value = ev_r.bin_width_value;
        ev_nxt.data_word = ev_r.data_word;
        if (tok_in.valid)
        begin
            // a delimiter after a full field closes it and is then
            // judged as the first token of what follows
            if (state_r == CFSF_S_DATA && !is_data && !is_sob)
            begin
                if (field_full)
                    ev_nxt.field_end = 1'b1;
                else
                    ev_nxt.frame_err = 1'b1;
            end
            unique case (state_r)
                CFSF_S_FIELD, CFSF_S_DATA:
                begin
                    if (state_r == CFSF_S_DATA && is_data)
                    begin
                        ev_nxt.data_vld = 1'b1;
                        ev_nxt.data_word = tok_in.word;
                    end
                    else if (state_r == CFSF_S_DATA && is_sob)
                    begin
                        if (field_full)
                        begin
                            // one block too many: the field ran long
                            ev_nxt.frame_err = 1'b1;
                            state_nxt = CFSF_S_FIELD;
                            exp_two_nxt = 1'b0;
                            open_nxt = 1'b0;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + 6'h01;
                            ev_nxt.block_start = 1'b1;
                            ev_nxt.block_kind = tok_in.kind[2:0];
                            ev_nxt.block_index = cnt_r + 6'h01;
                            state_nxt = CFSF_S_BW;
                        end
                    end
                    else if (is_sof && (tok_in.kind == CFSF_TK_FIELD_TWO_START_CODE)
                        == exp_two_r && !ev_nxt.frame_err)
                    begin
                        ev_nxt.field_start = 1'b1;
                        ev_nxt.field_two = exp_two_r;
                        exp_two_nxt = !exp_two_r;
                        open_nxt = 1'b1;
                        cnt_nxt = CFSF_CNT_RST;
                        state_nxt = CFSF_S_TCODE;
                    end
                    else if (is_eos && open_r && !exp_two_r
                        && !ev_nxt.frame_err)
                    begin
                        ev_nxt.seq_end = 1'b1;
                        open_nxt = 1'b0;
                        state_nxt = CFSF_S_FIELD;
                    end
                    else
                    begin
                        // resync: wait for a field one start
                        ev_nxt.frame_err = 1'b1;
                        exp_two_nxt = 1'b0;
                        open_nxt = 1'b0;
                        state_nxt = CFSF_S_FIELD;
                    end
                end
                CFSF_S_TCODE:
                begin
                    if (tok_in.kind == CFSF_TK_TCODE)
                    begin
                        ev_nxt.timecode_vld = 1'b1;
                        ev_nxt.data_word = tok_in.word;
                        state_nxt = CFSF_S_FIRST;
                    end
                    else
                    begin
                        ev_nxt.frame_err = 1'b1;
                        exp_two_nxt = 1'b0;
                        open_nxt = 1'b0;
                        state_nxt = CFSF_S_FIELD;
                    end
                end
                CFSF_S_FIRST:
                begin
                    if (tok_in.kind == CFSF_TK_FIRST)
                    begin
                        ev_nxt.block_start = 1'b1;
                        ev_nxt.first_block = 1'b1;
                        ev_nxt.block_kind = CFSF_FIRST_KIND;
                        ev_nxt.block_index = CFSF_CNT_RST;
                        state_nxt = CFSF_S_BW;
                    end
                    else
                    begin
                        ev_nxt.frame_err = 1'b1;
                        exp_two_nxt = 1'b0;
                        open_nxt = 1'b0;
                        state_nxt = CFSF_S_FIELD;
                    end
                end
                CFSF_S_BW:
                begin
                    if (tok_in.kind == CFSF_TK_BW)
                    begin
                        ev_nxt.bw_vld = 1'b1;
                        ev_nxt.bin_width_value = tok_in.word[CFSF_BW_W-1:0];
                        state_nxt = CFSF_S_DATA;
                    end
                    else
                    begin
                        ev_nxt.frame_err = 1'b1;
                        exp_two_nxt = 1'b0;
                        open_nxt = 1'b0;
                        state_nxt = CFSF_S_FIELD;
                    end
                end
                default:
                begin
                    // mark code is never entered; treat as lost framing
                    ev_nxt.frame_err = 1'b1;
                    exp_two_nxt = 1'b0;
                    open_nxt = 1'b0;
                    state_nxt = CFSF_S_FIELD;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= CFSF_S_FIELD;
            exp_two_r <= 1'b0;
            open_r <= 1'b0;
            cnt_r <= CFSF_CNT_RST;
        end
        else
        begin
            state_r <= state_nxt;
            exp_two_r <= exp_two_nxt;
            open_r <= open_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // event word registered alone so every output leaves a flip-flop
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ev_r <= '0;
        end
        else
        begin
            ev_r <= ev_nxt;
        end
    end

    assign ev_out = ev_r;
    assign seq_open = open_r;
endmodule

/* design/cfsf_pkg.sv */
// shared token, event and state definitions for the stream framer
package cfsf_pkg;
    localparam int CFSF_WORD_W = 32;
    localparam int CFSF_BW_W = 16;
    localparam int CFSF_CNT_W = 6;
    localparam logic [5:0] CFSF_BLOCKS_DEF = 6'h29;
    localparam logic [5:0] CFSF_CNT_RST = 6'h00;
    localparam logic [2:0] CFSF_FIRST_KIND = 3'h4;

    typedef enum logic [3:0] {
        CFSF_TK_DATA = 4'h0,
        CFSF_TK_BLOCK_START_KIND_ONE = 4'h1,
        CFSF_TK_BLOCK_START_KIND_TWO = 4'h2,
        CFSF_TK_BLOCK_START_KIND_THREE = 4'h3,
        CFSF_TK_BLOCK_START_KIND_FOUR = 4'h4,
        CFSF_TK_BLOCK_START_KIND_FIVE = 4'h5,
        CFSF_TK_FIRST = 4'h6,
        CFSF_TK_FIELD_ONE_START_CODE = 4'h7,
        CFSF_TK_FIELD_TWO_START_CODE = 4'h8,
        CFSF_TK_EOS = 4'h9,
        CFSF_TK_TCODE = 4'ha,
        CFSF_TK_BW = 4'hb
    } cfsf_tok_e;

    typedef struct packed {
        logic valid;
        cfsf_tok_e kind;
        logic [CFSF_WORD_W-1:0] word;
    } cfsf_tok_s;

    typedef struct packed {
        logic field_start;
        logic field_two;
        logic timecode_vld;
        logic block_start;
        logic first_block;
        logic [2:0] block_kind;
        logic [CFSF_CNT_W-1:0] block_index;
        logic bw_vld;
        logic [CFSF_BW_W-1:0] bin_width_value;
        logic data_vld;
        logic [CFSF_WORD_W-1:0] data_word;
        logic field_end;
        logic seq_end;
        logic frame_err;
    } cfsf_ev_s;

    typedef enum logic [2:0] {
        CFSF_S_FIELD = 3'b000,
        CFSF_S_TCODE = 3'b001,
        CFSF_S_FIRST = 3'b011,
        CFSF_S_BW = 3'b010,
        CFSF_S_DATA = 3'b110,
        CFSF_S_MARK = 3'b111
    } cfsf_state_e;
endpackage

/* sim/cfsf_framer_assertions.sv */
// checker of framer event order and tagging
`timescale 1ns/1ps
module cfsf_framer_assertions
    import cfsf_pkg::*;
#(
    parameter logic [5:0] BLOCKS = CFSF_BLOCKS_DEF
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire cfsf_tok_s tok_in,
    input wire cfsf_ev_s ev_out,
    input wire logic seq_open
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sof_open_a: assert property (
        tok_in.valid && tok_in.kind == CFSF_TK_FIELD_ONE_START_CODE && !seq_open
        |=> ev_out.field_start && !ev_out.field_two && seq_open)
        else $error("field one start lost");
    closed_err_a: assert property (
        tok_in.valid && tok_in.kind != CFSF_TK_FIELD_ONE_START_CODE && !seq_open
        |=> ev_out.frame_err) else $error("closed stream took token");
    err_shut_a: assert property (
        ev_out.frame_err |-> !seq_open) else $error("open after error");
    first_tag_a: assert property (
        ev_out.first_block |-> ev_out.block_start &&
        ev_out.block_kind == CFSF_FIRST_KIND && ev_out.block_index == 6'h00)
        else $error("first block tag wrong");
    start_cause_a: assert property (
        ev_out.field_start |-> $past(tok_in.valid) &&
        $past(tok_in.kind) inside {CFSF_TK_FIELD_ONE_START_CODE, CFSF_TK_FIELD_TWO_START_CODE})
        else $error("field start without delimiter");
    seq_end_a: assert property (
        ev_out.seq_end |-> ev_out.field_end && ev_out.field_two && !seq_open)
        else $error("sequence end misplaced");
    event_quiet_a: assert property (
        !tok_in.valid |=> !(ev_out.block_start || ev_out.bw_vld ||
        ev_out.data_vld || ev_out.field_start || ev_out.frame_err))
        else $error("event without token");
    block_index_a: assert property (
        ev_out.block_start && !ev_out.first_block |->
        ev_out.block_index inside {[1:BLOCKS]} &&
        ev_out.block_kind inside {[1:5]})
        else $error("block tag out of range");
    timecode_word_a: assert property (
        ev_out.timecode_vld |-> ev_out.data_word == $past(tok_in.word))
        else $error("timecode word wrong");
    cover property (ev_out.field_end && ev_out.field_two);
    cover property (ev_out.seq_end);
    cover property (ev_out.frame_err);
endmodule
bind cfsf_framer cfsf_framer_assertions #(.BLOCKS(BLOCKS)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .tok_in(tok_in), .ev_out(ev_out),
    .seq_open(seq_open));

/* sim/cfsf_host_model.sv */
// host model that feeds stream tokens
`timescale 1ns/1ps
module cfsf_host_model
    import cfsf_pkg::*;
(
    input wire logic clk,
    output cfsf_tok_s tok
);
    initial tok = '0;
    task automatic put(input cfsf_tok_e k, input logic [31:0] w);
        @(negedge clk);
        tok <= '{1'b1, k, w};
    endtask
    // released payload inverts so a stale word never looks valid
    task automatic idle();
        @(negedge clk);
        tok <= '{1'b0, cfsf_tok_e'(~tok.kind), ~tok.word};
    endtask
endmodule

/* sim/tb_cfsf_framer.sv */
// self-checking bench for the stream framer
`timescale 1ns/1ps
module tb_cfsf_framer;
    import cfsf_pkg::*;
    localparam logic [5:0] NBLK = CFSF_BLOCKS_DEF;
    logic clk;
    logic sys_rst;
    cfsf_tok_s tok_in;
    cfsf_ev_s ev_out;
    logic seq_open;
    int error_cnt = 0;
    int cmp_count = 0;
    cfsf_framer #(.BLOCKS(NBLK)) DUT (.clk(clk), .sys_rst(sys_rst),
        .tok_in(tok_in), .ev_out(ev_out), .seq_open(seq_open));
    cfsf_host_model host (.clk(clk), .tok(tok_in));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tk(cfsf_tok_e k, logic [31:0] w, logic [7:0] e);
        host.put(k, w);
        @(posedge clk);
        #1;
        chk("pulses", 32'(e), 32'({ev_out.field_start, ev_out.timecode_vld,
            ev_out.block_start, ev_out.bw_vld, ev_out.data_vld,
            ev_out.field_end, ev_out.seq_end, ev_out.frame_err}));
    endtask
    task automatic body(int f);
        cfsf_tok_e k;
        chk("field two", 32'(f), 32'(ev_out.field_two));
        tk(CFSF_TK_TCODE, 32'h1234 + f, 8'h40);
        chk("timecode", 32'h1234 + f, ev_out.data_word);
        tk(CFSF_TK_FIRST, 32'h0, 8'h20);
        chk("first", 32'({1'b1, CFSF_FIRST_KIND, CFSF_CNT_RST}),
            32'({ev_out.first_block, ev_out.block_kind,
            ev_out.block_index}));
        tk(CFSF_TK_BW, 32'h1ddc, 8'h10);
        chk("first bw", 32'h1ddc, 32'(ev_out.bin_width_value));
        tk(CFSF_TK_DATA, 32'hcafe, 8'h08);
        chk("first data", 32'hcafe, ev_out.data_word);
        for (int i = 1; i <= NBLK; i++)
        begin
            k = cfsf_tok_e'((i + 3 * f) % 5 + 1);
            tk(k, 32'h0, 8'h20);
            chk("block", 32'({k[2:0], 6'(i)}),
                32'({ev_out.block_kind, ev_out.block_index}));
            tk(CFSF_TK_BW, 32'h100 + i, 8'h10);
            chk("bw", 32'h100 + i, 32'(ev_out.bin_width_value));
            // block two carries no data words
            if (i != 2)
            begin
                tk(CFSF_TK_DATA, 32'(i), 8'h08);
                chk("data", 32'(i), ev_out.data_word);
            end
        end
    endtask
    task automatic t_frame();
        tk(CFSF_TK_FIELD_ONE_START_CODE, 32'h0, 8'h80);
        body(0);
        tk(CFSF_TK_FIELD_TWO_START_CODE, 32'h0, 8'h84);
        body(1);
        tk(CFSF_TK_FIELD_ONE_START_CODE, 32'h0, 8'h84);
        body(0);
        tk(CFSF_TK_FIELD_TWO_START_CODE, 32'h0, 8'h84);
        body(1);
        tk(CFSF_TK_EOS, 32'h0, 8'h06);
        host.idle();
        $display("t_frame done");
    endtask
    task automatic t_err();
        tk(CFSF_TK_DATA, 32'h0, 8'h01);
        tk(CFSF_TK_FIELD_TWO_START_CODE, 32'h0, 8'h01);
        tk(CFSF_TK_FIELD_ONE_START_CODE, 32'h0, 8'h80);
        tk(CFSF_TK_TCODE, 32'h0, 8'h40);
        tk(CFSF_TK_DATA, 32'h0, 8'h01);
        tk(CFSF_TK_FIELD_ONE_START_CODE, 32'h0, 8'h80);
        tk(CFSF_TK_TCODE, 32'h0, 8'h40);
        tk(CFSF_TK_FIRST, 32'h0, 8'h20);
        tk(CFSF_TK_BW, 32'h5, 8'h10);
        tk(CFSF_TK_FIRST, 32'h0, 8'h01);
        tk(CFSF_TK_FIELD_ONE_START_CODE, 32'h0, 8'h80);
        body(0);
        tk(CFSF_TK_BLOCK_START_KIND_ONE, 32'h0, 8'h01);
        chk("open", 32'h0, 32'(seq_open));
        tk(CFSF_TK_EOS, 32'h0, 8'h01);
        host.idle();
        $display("t_err done");
    endtask
    task automatic t_rst();
        tk(CFSF_TK_FIELD_ONE_START_CODE, 32'h0, 8'h80);
        chk("open", 32'h1, 32'(seq_open));
        host.idle();
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        chk("open", 32'h0, 32'(seq_open));
        sys_rst = 1'b0;
        tk(CFSF_TK_FIELD_TWO_START_CODE, 32'h0, 8'h01);
        host.idle();
        $display("t_rst done");
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        t_frame();
        t_err();
        t_rst();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
